/* edpc_check.sv */
// file: execute-disable and reserved-bit page checker with APB registers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RL1: no-execute pages fault on instruction fetch
// RL2: no-execute only in extended or long paging
// RL3: user/supervisor and write checks left untouched
// RL4: identification bit 20 reports no-execute support
// RL5: enable bit 11 turns enforcement on
// RL6: enable register present if bit 20/29
// RL7: enable write without feature gives protection fault
// RL8: enable register field layout 0,8,10,11
// RL9: bit 63 at any level blocks fetch
// RL10: each level's bit 63 judged independently
// RL11: legacy extended: directory and table, large directory
// RL12: reserved checks follow mode and address width
// RL13: choose 4M or plain mode from controls
// RL14: extension control selects extended mode always; code selects long mode instead when long_mode_active is set
// RL15: 4M directory checks bit 21 only
// RL16: extended mode reserved ranges with enable
// RL17: long mode reserved ranges with enable
// RL18: enable off makes bit 63 reserved
// RL19: check only on new translation buffer fill; code applies it to no-execute only, reserved check also runs on hits
// RL20: reserved bit set aborts with page fault
// RL21: enable bit zero after reset
module edpc_check #(
	parameter logic no_exec_supported = 1'b1,
	parameter logic long_mode_supported = 1'b1,
	parameter logic [7:0] phys_addr_width = edpc_pkg::PHYS_WIDTH_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic phys_addr_extension,
	input wire logic page_size_extension,
	input wire logic walk_valid,
	input wire logic walk_fetch,
	input wire logic walk_buf_hit,
	input wire logic [3:0] walk_level_used,
	input wire logic walk_large_page,
	input wire logic [63:0] top_level_table_entry,
	input wire logic [63:0] pointer_table_entry,
	input wire logic [63:0] directory_entry,
	input wire logic [63:0] table_entry,
	output logic no_exec_enable,
	output logic long_mode_enable,
	output logic long_mode_active,
	output logic syscall_enable,
	output logic check_done,
	output logic page_fault,
	output logic fault_no_exec,
	output logic fault_reserved,
	output logic general_protection_fault
);
	edpc_pkg::edpc_mode_e mode;
	logic efe_present;
	logic apb_wr;
	logic apb_rd;
	logic addr_ok;
	logic [63:0] ext_mask;
	logic [63:0] long_mask;
	logic [63:0] low_lp_mask;
	logic [63:0] rsv_tle;
	logic [63:0] rsv_ptr;
	logic [63:0] rsv_de;
	logic [63:0] rsv_te;
	logic [3:0] xd_hit;
	logic [3:0] rsv_hit;
	logic chk_fetch;
	logic next_nx_fault;
	logic next_rsv_fault;
	logic [31:0] status;

	// feature bit 20 or 29 provides the register
	assign efe_present = no_exec_supported | long_mode_supported;
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & penable & ~pwrite;
	assign addr_ok = (paddr == edpc_pkg::OFF_EFE_LO) | (paddr == edpc_pkg::OFF_EFE_HI) |
		(paddr == edpc_pkg::OFF_ID_EXT1) | (paddr == edpc_pkg::OFF_ID_EXT8) |
		(paddr == edpc_pkg::OFF_STATUS);
	assign pready = 1'b1;

	// RL13 RL14 mode selection
	always_comb begin
		if (long_mode_active) begin
			mode = edpc_pkg::EDPC_MODE_LONG;
		end else if (phys_addr_extension) begin
			mode = edpc_pkg::EDPC_MODE_EXT;
		end else if (page_size_extension) begin
			mode = edpc_pkg::EDPC_MODE_LARGE36;
		end else begin
			mode = edpc_pkg::EDPC_MODE_PLAIN;
		end
	end

	// RL12 masks from the physical address width
	always_comb begin
		ext_mask = '0;
		long_mask = '0;
		low_lp_mask = '0;
		for (int i = 0; i < 64; i++) begin
			if (i >= int'(phys_addr_width) && i <= edpc_pkg::EXT_LIMIT) begin
				ext_mask[i] = 1'b1;
			end
			if (i >= int'(phys_addr_width) && i <= edpc_pkg::LONG_LIMIT) begin
				long_mask[i] = 1'b1;
			end
			if (i >= edpc_pkg::LP_RSV_LO && i <= edpc_pkg::LP_RSV_HI) begin
				low_lp_mask[i] = 1'b1;
			end
		end
	end

	// reserved masks per level and mode
	always_comb begin
		rsv_tle = '0;
		rsv_ptr = '0;
		rsv_de = '0;
		rsv_te = '0;
		unique case (mode)
			edpc_pkg::EDPC_MODE_PLAIN: begin
				rsv_de = '0;
			end
			// RL15 only bit 21 of a 4M directory
			edpc_pkg::EDPC_MODE_LARGE36: begin
				rsv_de[edpc_pkg::LARGE36_RSV_BIT] = walk_large_page;
			end
			// RL16 extended-address reserved ranges
			edpc_pkg::EDPC_MODE_EXT: begin
				rsv_ptr = ext_mask | edpc_pkg::PDPT_RSV_LOW;
				rsv_ptr[edpc_pkg::XD_BIT] = 1'b1;
				rsv_de = ext_mask | (walk_large_page ? low_lp_mask : '0);
				rsv_te = ext_mask;
				// RL18 bit 63 reserved when disabled
				rsv_de[edpc_pkg::XD_BIT] = ~no_exec_enable;
				rsv_te[edpc_pkg::XD_BIT] = ~no_exec_enable;
			end
			// RL17 long mode reserved ranges
			edpc_pkg::EDPC_MODE_LONG: begin
				rsv_tle = long_mask;
				rsv_ptr = long_mask;
				rsv_de = long_mask | (walk_large_page ? low_lp_mask : '0);
				rsv_te = long_mask;
				// RL18 bit 63 reserved when disabled
				rsv_tle[edpc_pkg::XD_BIT] = ~no_exec_enable;
				rsv_ptr[edpc_pkg::XD_BIT] = ~no_exec_enable;
				rsv_de[edpc_pkg::XD_BIT] = ~no_exec_enable;
				rsv_te[edpc_pkg::XD_BIT] = ~no_exec_enable;
			end
		endcase
	end

	// RL10 RL11 per-level hits, large pages skip table level
	always_comb begin
		xd_hit[3] = top_level_table_entry[edpc_pkg::XD_BIT] & (mode == edpc_pkg::EDPC_MODE_LONG);
		xd_hit[2] = pointer_table_entry[edpc_pkg::XD_BIT] & (mode == edpc_pkg::EDPC_MODE_LONG);
		xd_hit[1] = directory_entry[edpc_pkg::XD_BIT];
		xd_hit[0] = table_entry[edpc_pkg::XD_BIT] & ~walk_large_page;
		rsv_hit[3] = |(top_level_table_entry & rsv_tle);
		rsv_hit[2] = |(pointer_table_entry & rsv_ptr);
		rsv_hit[1] = |(directory_entry & rsv_de);
		rsv_hit[0] = |(table_entry & rsv_te) & ~walk_large_page;
		xd_hit = xd_hit & walk_level_used;
		rsv_hit = rsv_hit & walk_level_used;
	end

	// RL19 check on fetch that fills the buffer
	assign chk_fetch = walk_valid & walk_fetch & ~walk_buf_hit;
	// RL1 RL2 RL9 no-execute fault only in extended modes
	assign next_nx_fault = chk_fetch & no_exec_enable & (|xd_hit) &
		((mode == edpc_pkg::EDPC_MODE_EXT) | (mode == edpc_pkg::EDPC_MODE_LONG));
	// RL20 reserved bit aborts the access
	assign next_rsv_fault = walk_valid & (|rsv_hit);

	// RL3 privilege checks live elsewhere; only adds faults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			check_done <= 1'b0;
			page_fault <= 1'b0;
			fault_no_exec <= 1'b0;
			fault_reserved <= 1'b0;
		end else begin
			check_done <= walk_valid;
			page_fault <= next_nx_fault | next_rsv_fault;
			fault_no_exec <= next_nx_fault;
			fault_reserved <= next_rsv_fault;
		end
	end

	// RL5 RL8 RL21 enable register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			syscall_enable <= edpc_pkg::EFE_RESET[edpc_pkg::SYSCALL_BIT];
			long_mode_enable <= edpc_pkg::EFE_RESET[edpc_pkg::LONG_EN_BIT];
			long_mode_active <= edpc_pkg::EFE_RESET[edpc_pkg::LONG_ACT_BIT];
			no_exec_enable <= edpc_pkg::EFE_RESET[edpc_pkg::NOEXEC_EN_BIT];
		end else if (apb_wr && paddr == edpc_pkg::OFF_EFE_LO && efe_present) begin
			// RL7 illegal enable write leaves the register unchanged
			if (!(pwdata[edpc_pkg::NOEXEC_EN_BIT] && !no_exec_supported)) begin
				if (pstrb[0]) begin
					syscall_enable <= pwdata[edpc_pkg::SYSCALL_BIT];
				end
				if (pstrb[1]) begin
					long_mode_enable <= pwdata[edpc_pkg::LONG_EN_BIT] & long_mode_supported;
					no_exec_enable <= pwdata[edpc_pkg::NOEXEC_EN_BIT];
				end
			end
		end else begin
			long_mode_active <= long_mode_enable & phys_addr_extension;
		end
	end

	// RL7 protection fault pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			general_protection_fault <= 1'b0;
		end else begin
			general_protection_fault <= apb_wr & (paddr == edpc_pkg::OFF_EFE_LO) & pstrb[1] &
				pwdata[edpc_pkg::NOEXEC_EN_BIT] & ~no_exec_supported;
		end
	end

	assign status = {28'h0000000, fault_reserved, fault_no_exec, page_fault, check_done};
	assign pslverr = psel & penable & (~addr_ok | (apb_wr & (paddr != edpc_pkg::OFF_EFE_LO)) |
		(apb_wr & pstrb[1] & pwdata[edpc_pkg::NOEXEC_EN_BIT] & ~no_exec_supported));

	// RL4 RL6 read mux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			unique case (paddr)
				edpc_pkg::OFF_EFE_LO: begin
					prdata[edpc_pkg::SYSCALL_BIT] <= syscall_enable;
					prdata[edpc_pkg::LONG_EN_BIT] <= long_mode_enable;
					prdata[edpc_pkg::LONG_ACT_BIT] <= long_mode_active;
					prdata[edpc_pkg::NOEXEC_EN_BIT] <= no_exec_enable;
				end
				edpc_pkg::OFF_ID_EXT1: begin
					prdata[edpc_pkg::ID_NOEXEC_BIT] <= no_exec_supported;
					prdata[edpc_pkg::ID_LM_BIT] <= long_mode_supported;
				end
				edpc_pkg::OFF_ID_EXT8: begin
					prdata[7:0] <= phys_addr_width;
				end
				edpc_pkg::OFF_STATUS: begin
					prdata <= status;
				end
				default: begin
					prdata <= 32'h0000_0000;
				end
			endcase
		end
	end
endmodule : edpc_check
`default_nettype wire

/* edpc_check_props.sv */
// assertions on the page checker ports
`timescale 1ns/1ps
`default_nettype none
module edpc_check_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic phys_addr_extension,
	input wire logic walk_valid,
	input wire logic walk_fetch,
	input wire logic walk_buf_hit,
	input wire logic no_exec_enable,
	input wire logic check_done,
	input wire logic page_fault,
	input wire logic fault_no_exec,
	input wire logic fault_reserved
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_done; walk_valid |=> check_done; endproperty
	a_done: assert property (p_done) else $error("walk not done");
	property p_pf; page_fault == (fault_no_exec || fault_reserved); endproperty
	a_pf: assert property (p_pf) else $error("fault sum");
	property p_nx; fault_no_exec |-> $past(walk_valid && walk_fetch && !walk_buf_hit
		&& phys_addr_extension && no_exec_enable); endproperty
	a_nx: assert property (p_nx) else $error("no exec cause");
	property p_hit; walk_valid && walk_buf_hit |=> !fault_no_exec; endproperty
	a_hit: assert property (p_hit) else $error("hit faulted");
	property p_off; walk_valid && !(no_exec_enable && phys_addr_extension) |=> !fault_no_exec;
	endproperty
	a_off: assert property (p_off) else $error("fault unarmed");
	property p_data; walk_valid && !walk_fetch |=> !fault_no_exec; endproperty
	a_data: assert property (p_data) else $error("data faulted");
	property p_wr; psel && penable && pwrite && paddr == 12'h000 && !pslverr
		|=> no_exec_enable == $past(pwdata[11]); endproperty
	a_wr: assert property (p_wr) else $error("enable write");
	property p_rst; $past(!presetn) |-> !no_exec_enable; endproperty
	a_rst: assert property (p_rst) else $error("enable reset");
endmodule : edpc_check_props
`default_nettype wire

/* edpc_check_tb.sv */
// self-checking bench for the page checker
`timescale 1ns/1ps
`default_nettype none
module edpc_check_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, phys_addr_extension;
	logic page_size_extension, walk_en, walk_valid, walk_fetch, walk_buf_hit, walk_large_page;
	logic no_exec_enable, long_mode_enable, long_mode_active, syscall_enable, check_done;
	logic page_fault, fault_no_exec, fault_reserved, general_protection_fault, err;
	logic m_noexec, m_long, e_v, e_noexec, e_rsv, xd;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, walk_level_used;
	logic [63:0] top_level_table_entry, pointer_table_entry, directory_entry, table_entry;
	int n_fail, total_checks, n;
	edpc_check edpc_check_i (.*);
	edpc_walker edpc_walker_i (.*);
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		n_fail += int'(n == 50);
		if (n == 50) tally_and_finish();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// reference outcome of each walk, compared at the next edge
	always @(posedge pclk) begin
		if (presetn) begin
			chk("done", e_v, check_done);
			chk("no exec", e_noexec, fault_no_exec);
			chk("reserved", e_rsv, fault_reserved);
			chk("page fault", e_noexec | e_rsv, page_fault);
			chk("prot fault", 32'h0, general_protection_fault);
		end
		xd = walk_level_used[3] & top_level_table_entry[63] | walk_level_used[2]
			& pointer_table_entry[63] | directory_entry[63] | walk_level_used[0] & table_entry[63];
		e_v <= walk_valid;
		e_noexec <= walk_valid & walk_fetch & !walk_buf_hit & phys_addr_extension & m_noexec & xd;
		e_rsv <= walk_valid & (phys_addr_extension & (!m_noexec & xd | directory_entry[40])
			| !phys_addr_extension & page_size_extension & walk_large_page & directory_entry[21]);
	end
	initial begin
		void'($urandom(99));
		{presetn, psel, penable, pwrite, phys_addr_extension, page_size_extension} = '0;
		{walk_en, m_noexec, m_long, paddr, pwdata, n_fail, total_checks} = '0;
		pstrb = 4'hF;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h000, 32'h0);
		chk("enable reset", 32'h0, rd);
		apb(1'b0, 12'h008, 32'h0);
		chk("id leaf", 32'h2010_0000, rd & 32'h2010_0000);
		apb(1'b1, 12'h020, 32'h0);
		chk("unmapped", 32'h1, err);
		for (int m = 0; m < 8; m++) begin
			// mode in m[2:1]: plain, 4M, extended, long; enable in m[0]
			m_noexec = m[0];
			m_long = m[2] & m[1];
			phys_addr_extension <= m[2];
			page_size_extension <= m[1];
			apb(1'b1, 12'h000, {20'h0, m_noexec, 2'h0, m_long, 7'h0, 1'b1});
			apb(1'b0, 12'h000, 32'h0);
			chk("enable reg", {20'h0, m_noexec, m_long, 1'b0, m_long, 7'h0, 1'b1}, rd);
			walk_en <= 1'b1;
			repeat (60) @(posedge pclk);
			walk_en <= 1'b0;
			repeat (3) @(posedge pclk);
		end
		tally_and_finish();
	end
endmodule : edpc_check_tb
bind edpc_check edpc_check_props edpc_check_props_i (.*);
`default_nettype wire

/* edpc_pkg.sv */
// package: constants for the execute-disable page checker
package edpc_pkg;
	// register offsets (byte addresses)
	localparam logic [11:0] OFF_EFE_LO = 12'h000;
	localparam logic [11:0] OFF_EFE_HI = 12'h004;
	localparam logic [11:0] OFF_ID_EXT1 = 12'h008;
	localparam logic [11:0] OFF_ID_EXT8 = 12'h00C;
	localparam logic [11:0] OFF_STATUS = 12'h010;
	// extended feature enable fields
	localparam int SYSCALL_BIT = 0;
	localparam int LONG_EN_BIT = 8;
	localparam int LONG_ACT_BIT = 10;
	localparam int NOEXEC_EN_BIT = 11;
	localparam logic [31:0] EFE_RESET = 32'h0000_0000;
	// identification leaf bits
	localparam int ID_NOEXEC_BIT = 20;
	localparam int ID_LM_BIT = 29;
	// entry fields
	localparam int XD_BIT = 63;
	localparam int PS_BIT = 7;
	localparam int LARGE36_RSV_BIT = 21;
	localparam int LP_RSV_HI = 20;
	localparam int LP_RSV_LO = 13;
	localparam int EXT_LIMIT = 62;
	localparam int LONG_LIMIT = 51;
	localparam logic [63:0] PDPT_RSV_LOW = 64'h0000_0000_0000_01E6;
	localparam logic [7:0] PHYS_WIDTH_DEF = 8'h24;
	// paging modes
	typedef enum logic [1:0] {
		EDPC_MODE_PLAIN,
		EDPC_MODE_LARGE36,
		EDPC_MODE_EXT,
		EDPC_MODE_LONG
	} edpc_mode_e;
endpackage : edpc_pkg

/* edpc_walker.sv */
// walker model issuing random table walks
`timescale 1ns/1ps
`default_nettype none
module edpc_walker (
	input wire logic pclk,
	input wire logic walk_en,
	input wire logic phys_addr_extension,
	input wire logic page_size_extension,
	input wire logic long_mode_active,
	output logic walk_valid,
	output logic walk_fetch,
	output logic walk_buf_hit,
	output logic walk_large_page,
	output logic [3:0] walk_level_used,
	output logic [63:0] top_level_table_entry,
	output logic [63:0] pointer_table_entry,
	output logic [63:0] directory_entry,
	output logic [63:0] table_entry
);
	logic f, lg;
	// entry whose reserved fields are clear apart from bit 63
	function automatic logic [63:0] ent(input logic x);
		return {x, 35'h0, 28'($urandom) & 28'hFC01E19};
	endfunction : ent
	initial {walk_valid, walk_fetch, walk_buf_hit, walk_large_page, walk_level_used} = '0;
	initial {top_level_table_entry, pointer_table_entry, directory_entry, table_entry} = '0;
	always @(posedge pclk) begin
		f = 1'($urandom);
		lg = (phys_addr_extension | page_size_extension) & 1'($urandom);
		walk_valid <= walk_en & 1'($urandom);
		walk_fetch <= f;
		walk_buf_hit <= 2'($urandom) == 2'h0;
		walk_large_page <= lg;
		walk_level_used <= {long_mode_active, phys_addr_extension, 1'b1, !lg};
		top_level_table_entry <= ent(1'($urandom));
		pointer_table_entry <= ent(long_mode_active & 1'($urandom));
		// data walks may carry bits 40 and 21
		directory_entry <= ent(1'($urandom))
			| {23'h0, !f & 1'($urandom), 18'h0, !f & 1'($urandom), 21'h0};
		table_entry <= ent(1'($urandom));
	end
endmodule : edpc_walker
`default_nettype wire
